// ===== aout_ctrl_regs.vh
// Word offsets, field positions and timing constants for aout_ctrl
`ifndef AOUT_CTRL_REGS_VH
`define AOUT_CTRL_REGS_VH

// Parameter memory word offsets, relative to the unit's base word
`define PM_OUT_SELECT 6'h00
`define PM_RANGE 6'h01
`define PM_CH1_STOP_POLICY 6'h02
`define PM_CH2_STOP_POLICY 6'h03
`define PM_TIMING 6'h12
`define PM_CH1_SCALE_LOW 6'h13
`define PM_CH1_SCALE_HIGH 6'h14
`define PM_CH2_SCALE_LOW 6'h15
`define PM_CH2_SCALE_HIGH 6'h16
`define PM_CURRENT_SELECT 6'h23

// I/O exchange area word offsets, relative to the unit's base word
`define IO_CONV_ENABLE 4'h0
`define IO_CH1_SET_VALUE 4'h1
`define IO_CH2_SET_VALUE 4'h2
`define IO_STATUS 4'h9

// Field positions
`define TIMING_LSB 8
`define TIMING_MSB 15
`define STAT_SCALE_ERR_LSB 8

// Field encodings
`define TIMING_FAST 8'h01
`define RANGE_BIPOLAR_10 2'h0
`define RANGE_UNIPOLAR_10 2'h1
`define RANGE_ONE_TO_FIVE 2'h2
`define RANGE_ZERO_TO_FIVE 2'h3
`define POLICY_MIN 8'h00
`define POLICY_KEEP 8'h01
`define POLICY_MAX 8'h02

// Reset values
`define PM_RESET 16'h0000

// Resolution, scaling limits
`define RES_NORMAL 4000
`define RES_FAST 8000
`define SCALE_LIMIT 32000

// Timing: system clock period and the per-channel periods, in nanoseconds
`define CLK_PERIOD_NS 100
`define PERIOD_NORMAL_NS 1000000
`define PERIOD_FAST_NS 500000

`endif

// ===== aout_ctrl.v
// Two-channel analog output control: enables, stop policy, scaling
`timescale 1ns/1ps
`default_nettype none
`include "aout_ctrl_regs.vh"
module aout_ctrl #(
  parameter PERIOD_NORMAL_CYC = `PERIOD_NORMAL_NS / `CLK_PERIOD_NS,
  parameter PERIOD_FAST_CYC = `PERIOD_FAST_NS / `CLK_PERIOD_NS
) (
  input wire clk_sys,
  input wire rst,
  input wire cfgWrEn,
  input wire [5:0] cfgAddr,
  input wire [15:0] cfgWrData,
  input wire restartReq,
  input wire ioWrEn,
  input wire [3:0] ioAddr,
  input wire [15:0] ioWrData,
  input wire [3:0] ioRdAddr,
  output reg [15:0] ioRdData,
  input wire progModeIn,
  input wire fatalErrIn,
  input wire busErrIn,
  input wire loadOffIn,
  input wire controllerTimeoutIn,
  input wire [1:0] adjustOtherIn,
  input wire [1:0] ratioActiveIn,
  input wire [1:0] inputDisconnectIn,
  output reg [31:0] dacCode,
  output reg [3:0] dacRange,
  output reg [1:0] dacCurrent,
  output reg [1:0] convActive,
  output reg [1:0] convStrobe,
  output reg fastMode
);

  // Staged configuration, written any time by the controller
  reg [15:0] stgSelect_ff, stgRange_ff, stgCurrent_ff, stgTiming_ff;
  reg [15:0] stgPolicy_ff [0:1];
  reg [15:0] stgLow_ff [0:1];
  reg [15:0] stgHigh_ff [0:1];
  // Active configuration, loaded only at power-up or restart
  reg [15:0] actSelect_ff, actRange_ff, actCurrent_ff, actTiming_ff;
  reg [15:0] actPolicy_ff [0:1];
  reg [15:0] actLow_ff [0:1];
  reg [15:0] actHigh_ff [0:1];
  reg loadPend_ff;
  // Exchange words
  reg [1:0] convEn_ff;
  reg [15:0] setVal_ff [0:1];
  reg [1:0] setErr_ff;
  reg [1:0] scaleErr_ff;
  // Synchronisers for controller status pins
  reg [4:0] pinMeta_ff, pinSync_ff;
  reg progPrev_ff;
  // Slot sequencer
  reg [15:0] periodCnt_ff;
  reg slot_ff;

  wire progMode = pinSync_ff[0];
  wire fatalErr = pinSync_ff[1];
  wire busErr = pinSync_ff[2];
  wire loadOff = pinSync_ff[3];
  wire ctrlTimeout = pinSync_ff[4];
  wire fast = (actTiming_ff[`TIMING_MSB:`TIMING_LSB] == `TIMING_FAST);
  wire progEntry = progMode & ~progPrev_ff;
  wire unitStop = fatalErr | busErr | loadOff | ctrlTimeout;
  wire [15:0] periodLast = fast ? PERIOD_FAST_CYC[15:0] - 16'h0001 :
    PERIOD_NORMAL_CYC[15:0] - 16'h0001;
  wire slotEnd = (periodCnt_ff == periodLast);
  wire [1:0] chanOn = actSelect_ff[1:0];

  // Span constants held at the 20-bit working width of the scaler
  localparam signed [19:0] RES_N = `RES_NORMAL;
  localparam signed [19:0] RES_F = `RES_FAST;
  localparam signed [19:0] SPAN_LIM = `SCALE_LIMIT;
  localparam signed [19:0] PCT5_DIV = 20'sd20;

  // Per-channel computed values
  wire [15:0] chanCode [0:1];
  wire [15:0] chanStop [0:1];
  wire [15:0] chanZero [0:1];
  wire [1:0] chanSetErr;
  wire [1:0] chanScaleErr;
  wire [1:0] chanOk;

  // Two-flop synchronisers for the controller status pins
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pinMeta_ff <= 5'h00;
      pinSync_ff <= 5'h00;
      progPrev_ff <= 1'b0;
    end else begin
      pinMeta_ff <= {controllerTimeoutIn, loadOffIn, busErrIn, fatalErrIn,
        progModeIn};
      pinSync_ff <= pinMeta_ff;
      progPrev_ff <= pinSync_ff[0];
    end
  end

  // Staged and active configuration words
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stgSelect_ff <= `PM_RESET;
      stgRange_ff <= `PM_RESET;
      stgCurrent_ff <= `PM_RESET;
      stgTiming_ff <= `PM_RESET;
      stgPolicy_ff[0] <= `PM_RESET;
      stgPolicy_ff[1] <= `PM_RESET;
      stgLow_ff[0] <= `PM_RESET;
      stgLow_ff[1] <= `PM_RESET;
      stgHigh_ff[0] <= `PM_RESET;
      stgHigh_ff[1] <= `PM_RESET;
      actSelect_ff <= `PM_RESET;
      actRange_ff <= `PM_RESET;
      actCurrent_ff <= `PM_RESET;
      actTiming_ff <= `PM_RESET;
      actPolicy_ff[0] <= `PM_RESET;
      actPolicy_ff[1] <= `PM_RESET;
      actLow_ff[0] <= `PM_RESET;
      actLow_ff[1] <= `PM_RESET;
      actHigh_ff[0] <= `PM_RESET;
      actHigh_ff[1] <= `PM_RESET;
      loadPend_ff <= 1'b1;
    end else begin
      if (cfgWrEn) begin
        if (cfgAddr == `PM_OUT_SELECT) begin
          stgSelect_ff <= cfgWrData;
        end else if (cfgAddr == `PM_RANGE) begin
          stgRange_ff <= cfgWrData;
        end else if (cfgAddr == `PM_CH1_STOP_POLICY) begin
          stgPolicy_ff[0] <= cfgWrData;
        end else if (cfgAddr == `PM_CH2_STOP_POLICY) begin
          stgPolicy_ff[1] <= cfgWrData;
        end else if (cfgAddr == `PM_TIMING) begin
          stgTiming_ff <= cfgWrData;
        end else if (cfgAddr == `PM_CH1_SCALE_LOW) begin
          stgLow_ff[0] <= cfgWrData;
        end else if (cfgAddr == `PM_CH1_SCALE_HIGH) begin
          stgHigh_ff[0] <= cfgWrData;
        end else if (cfgAddr == `PM_CH2_SCALE_LOW) begin
          stgLow_ff[1] <= cfgWrData;
        end else if (cfgAddr == `PM_CH2_SCALE_HIGH) begin
          stgHigh_ff[1] <= cfgWrData;
        end else if (cfgAddr == `PM_CURRENT_SELECT) begin
          stgCurrent_ff <= cfgWrData;
        end
      end
      // Transfer to active set only at power-up or restart
      loadPend_ff <= restartReq;
      if (loadPend_ff) begin
        actSelect_ff <= stgSelect_ff;
        actRange_ff <= stgRange_ff;
        actCurrent_ff <= stgCurrent_ff;
        actTiming_ff <= stgTiming_ff;
        actPolicy_ff[0] <= stgPolicy_ff[0];
        actPolicy_ff[1] <= stgPolicy_ff[1];
        actLow_ff[0] <= stgLow_ff[0];
        actLow_ff[1] <= stgLow_ff[1];
        actHigh_ff[0] <= stgHigh_ff[0];
        actHigh_ff[1] <= stgHigh_ff[1];
      end
    end
  end

  // Exchange words: enable bits and set values
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      convEn_ff <= 2'h0;
      setVal_ff[0] <= 16'h0000;
      setVal_ff[1] <= 16'h0000;
    end else begin
      if (ioWrEn && ioAddr == `IO_CH1_SET_VALUE) begin
        setVal_ff[0] <= ioWrData;
      end
      if (ioWrEn && ioAddr == `IO_CH2_SET_VALUE) begin
        setVal_ff[1] <= ioWrData;
      end
      if (progEntry) begin
        convEn_ff <= 2'h0;
      end else if (ioWrEn && ioAddr == `IO_CONV_ENABLE) begin
        convEn_ff <= ioWrData[1:0];
      end
    end
  end

  // Per-channel range, scaling and error evaluation
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : chan
      reg signed [19:0] fs, lim5, loLim, hiLim, zeroV, stopV;
      reg signed [39:0] num, den, quo;
      reg signed [19:0] lo, hi, sv, raw, clamped;
      reg [1:0] rng;
      reg [7:0] pol;
      reg scaleBad, scaleOn;
      always @* begin
        rng = actRange_ff[2*g+1:2*g];
        pol = actPolicy_ff[g][7:0];
        fs = fast ? RES_F : RES_N;
        lim5 = fs / PCT5_DIV;
        // Converter code limits, -5% to +105% of the span
        if (rng == `RANGE_BIPOLAR_10) begin
          loLim = -(fs / 20'sd2) - lim5;
          hiLim = (fs / 20'sd2) + lim5;
        end else begin
          loLim = -lim5;
          hiLim = fs + lim5;
        end
        // Code that gives 0 V on this range
        zeroV = (rng == `RANGE_ONE_TO_FIVE) ? -(fs / 20'sd4) : 20'sd0;
        // Stop-state level, keep uses the driven code
        if (pol == `POLICY_MAX) begin
          stopV = hiLim;
        end else if (pol == `POLICY_KEEP) begin
          stopV = {{4{dacCode[16*g+15]}}, dacCode[16*g+15:16*g]};
        end else if (rng == `RANGE_BIPOLAR_10) begin
          stopV = 20'sd0;
        end else begin
          stopV = loLim;
        end
        lo = {{4{actLow_ff[g][15]}}, actLow_ff[g]};
        hi = {{4{actHigh_ff[g][15]}}, actHigh_ff[g]};
        sv = {{4{setVal_ff[g][15]}}, setVal_ff[g]};
        // Equal nonzero limits or limits beyond the allowed span
        scaleBad = ((lo == hi) && (lo != 20'sd0)) ||
          (lo > SPAN_LIM) || (lo < -SPAN_LIM) ||
          (hi > SPAN_LIM) || (hi < -SPAN_LIM);
        scaleOn = !fast && !ratioActiveIn[g] && !scaleBad &&
          (lo != hi);
        // Linear map, lower limit to zero scale, rounded to nearest
        num = (sv - lo) * fs;
        den = hi - lo;
        if (den < 0) begin
          num = -num;
          den = -den;
        end
        if (den == 0) begin
          quo = 40'sd0;
        end else if (num >= 0) begin
          quo = (2 * num + den) / (2 * den);
        end else begin
          quo = -((-2 * num + den) / (2 * den));
        end
        if (scaleOn) begin
          raw = $signed(quo[19:0]) -
            ((rng == `RANGE_BIPOLAR_10) ? fs / 20'sd2 : 20'sd0);
        end else begin
          raw = sv;
        end
        // Clamp after rounding
        if (raw < loLim) begin
          clamped = loLim;
        end else if (raw > hiLim) begin
          clamped = hiLim;
        end else begin
          clamped = raw;
        end
      end
      assign chanCode[g] = clamped[15:0];
      assign chanStop[g] = stopV[15:0];
      assign chanZero[g] = zeroV[15:0];
      assign chanSetErr[g] = (raw < loLim) || (raw > hiLim);
      assign chanScaleErr[g] = scaleBad & !fast & !ratioActiveIn[g];
      assign chanOk[g] = chanOn[g] & convEn_ff[g] & !adjustOtherIn[g] &
        !chanSetErr[g] & !unitStop &
        !(ratioActiveIn[g] & inputDisconnectIn[g]);
    end
  endgenerate

  // Slot sequencer, one channel per period, round robin
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      periodCnt_ff <= 16'h0000;
      slot_ff <= 1'b0;
    end else begin
      if (slotEnd || chanOn == 2'h0) begin
        periodCnt_ff <= 16'h0000;
      end else begin
        periodCnt_ff <= periodCnt_ff + 16'h0001;
      end
      // Skip an unselected channel so cycle = period x count
      if (slotEnd && chanOn[~slot_ff]) begin
        slot_ff <= ~slot_ff;
      end else if (!chanOn[slot_ff] && chanOn[~slot_ff]) begin
        slot_ff <= ~slot_ff;
      end
    end
  end

  // Converter drive, status and error bits
  integer i;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dacCode <= 32'h00000000;
      dacRange <= 4'h0;
      dacCurrent <= 2'h0;
      convActive <= 2'h0;
      convStrobe <= 2'h0;
      setErr_ff <= 2'h0;
      scaleErr_ff <= 2'h0;
      fastMode <= 1'b0;
    end else begin
      dacRange <= actRange_ff[3:0];
      fastMode <= fast;
      setErr_ff <= chanSetErr;
      scaleErr_ff <= chanScaleErr;
      convActive <= chanOk;
      for (i = 0; i < 2; i = i + 1) begin
        dacCurrent[i] <= (actRange_ff[2*i+1 -: 2] == `RANGE_ONE_TO_FIVE) &
          actCurrent_ff[i];
        convStrobe[i] <= 1'b0;
        if (!chanOn[i]) begin
          dacCode[16*i +: 16] <= chanZero[i];
        end else if (!chanOk[i]) begin
          dacCode[16*i +: 16] <= chanStop[i];
        end else if (slotEnd && slot_ff == i[0]) begin
          dacCode[16*i +: 16] <= chanCode[i];
          convStrobe[i] <= 1'b1;
        end
      end
    end
  end

  // Exchange area read port, one cycle latency
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ioRdData <= 16'h0000;
    end else begin
      if (ioRdAddr == `IO_CONV_ENABLE) begin
        ioRdData <= {14'h0000, convEn_ff};
      end else if (ioRdAddr == `IO_CH1_SET_VALUE) begin
        ioRdData <= setVal_ff[0];
      end else if (ioRdAddr == `IO_CH2_SET_VALUE) begin
        ioRdData <= setVal_ff[1];
      end else if (ioRdAddr == `IO_STATUS) begin
        ioRdData <= {6'h00, scaleErr_ff, 6'h00, setErr_ff};
      end else begin
        ioRdData <= 16'h0000;
      end
    end
  end

endmodule
`default_nettype wire

// ===== ctrl_model.sv
// Controller model: writes parameter words and exchange words
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
  input wire logic clk_sys,
  output logic cfgWrEn,
  output logic [5:0] cfgAddr,
  output logic [15:0] cfgWrData,
  output logic restartReq,
  output logic ioWrEn,
  output logic [3:0] ioAddr,
  output logic [15:0] ioWrData
);
  // Idle bus
  initial begin
    {cfgWrEn, cfgAddr, cfgWrData, restartReq, ioWrEn, ioAddr, ioWrData} = '0;
  end

  // One parameter word; released data shows its inverse
  task automatic cfg(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    cfgWrEn <= 1'b1;
    cfgAddr <= a;
    cfgWrData <= d;
    @(posedge clk_sys);
    cfgWrEn <= 1'b0;
    cfgWrData <= ~d;
  endtask

  // One exchange word, whole 16-bit value
  task automatic io(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    ioWrEn <= 1'b1;
    ioAddr <= a;
    ioWrData <= d;
    @(posedge clk_sys);
    ioWrEn <= 1'b0;
    ioWrData <= ~d;
  endtask

  // Restart so staged words become active
  task automatic restart;
    @(posedge clk_sys);
    restartReq <= 1'b1;
    @(posedge clk_sys);
    restartReq <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// ===== aout_ctrl_asserts.sv
// Checker: timing relations at the aout_ctrl ports
`timescale 1ns/1ps
`default_nettype none
module aout_ctrl_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic restartReq,
  input wire logic ioWrEn,
  input wire logic [3:0] ioAddr,
  input wire logic [15:0] ioWrData,
  input wire logic progModeIn,
  input wire logic fatalErrIn,
  input wire logic busErrIn,
  input wire logic loadOffIn,
  input wire logic controllerTimeoutIn,
  input wire logic [1:0] adjustOtherIn,
  input wire logic [31:0] dacCode,
  input wire logic [3:0] dacRange,
  input wire logic [1:0] dacCurrent,
  input wire logic [1:0] convActive,
  input wire logic [1:0] convStrobe,
  input wire logic fastMode
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // Slots and updates
  slot_apart_a: assert property (!(convStrobe[0] && convStrobe[1]))
    else $error("both channels loaded in one cycle");
  strobe_gap_a: assert property (convStrobe[0] |=> !convStrobe[0] [*8])
    else $error("channel 1 loads too close together");
  code_clamp_a: assert property (!fastMode |->
    $signed(dacCode[15:0]) >= -2200 && $signed(dacCode[15:0]) <= 4200)
    else $error("channel 1 code beyond clamp");
  // Stop causes
  prog_clear_a: assert property ($rose(progModeIn) |->
    ##[1:6] convActive == 2'b00)
    else $error("program mode did not clear conversion");
  fault_stop_a: assert property ((busErrIn || loadOffIn ||
    controllerTimeoutIn) [*5] |-> convActive == 2'b00)
    else $error("fault did not stop conversion");
  fatal_stop_a: assert property (fatalErrIn [*5] |-> !convActive[0])
    else $error("fatal error did not stop conversion");
  adjust_block_a: assert property (adjustOtherIn[0] [*3] |->
    !convActive[0])
    else $error("adjustment did not block conversion");
  enable_off_a: assert property (ioWrEn && ioAddr == 4'h0 &&
    !ioWrData[0] |-> ##2 !convActive[0])
    else $error("cleared enable left channel 1 running");
  // Configuration only moves on restart; current variant only on the 1 to 5 V range
  range_restart_a: assert property (!$stable(dacRange) ||
    !$stable(fastMode) |-> $past(restartReq) || $past(restartReq, 2) ||
    $past(restartReq, 3))
    else $error("configuration changed without restart");
  current_range_a: assert property (dacCurrent[0] |->
    dacRange[1:0] == 2'h2)
    else $error("current variant outside shared range");
endmodule

bind aout_ctrl aout_ctrl_asserts aout_ctrl_asserts_i (.clk_sys, .rst,
  .restartReq, .ioWrEn, .ioAddr, .ioWrData, .progModeIn, .fatalErrIn,
  .busErrIn, .loadOffIn, .controllerTimeoutIn, .adjustOtherIn, .dacCode,
  .dacRange, .dacCurrent, .convActive, .convStrobe, .fastMode);
`default_nettype wire

// ===== aout_ctrl_tb_top.sv
// Testbench: drives aout_ctrl through the controller model
`timescale 1ns/1ps
`default_nettype none
module aout_ctrl_tb_top;
  logic clk_sys, rst, cfgWrEn, restartReq, ioWrEn, fastMode;
  logic [5:0] cfgAddr;
  logic [15:0] cfgWrData, ioWrData, ioRdData;
  logic [3:0] ioAddr, ioRdAddr, dacRange;
  logic [10:0] flt;
  logic [31:0] dacCode, seed;
  logic [1:0] dacCurrent, convActive, convStrobe;
  logic [15:0] expQ[$];
  int n_fail, n_checks, k, r, p;
  logic [15:0] polTab [6] = '{16'hFF38, 16'h07D0, 16'h1068, 16'h0000,
    16'h07D0, 16'h0898};

  ctrl_model ctrl_model_i (.clk_sys, .cfgWrEn, .cfgAddr, .cfgWrData,
    .restartReq, .ioWrEn, .ioAddr, .ioWrData);
  aout_ctrl #(.PERIOD_NORMAL_CYC(20), .PERIOD_FAST_CYC(10)) aout_ctrl_i (
    .clk_sys, .rst, .cfgWrEn, .cfgAddr, .cfgWrData, .restartReq, .ioWrEn,
    .ioAddr, .ioWrData, .ioRdAddr, .ioRdData, .progModeIn(flt[0]),
    .fatalErrIn(flt[1]), .busErrIn(flt[2]), .loadOffIn(flt[3]),
    .controllerTimeoutIn(flt[4]), .adjustOtherIn(flt[6:5]),
    .ratioActiveIn(flt[8:7]), .inputDisconnectIn(flt[10:9]), .dacCode,
    .dacRange, .dacCurrent, .convActive, .convStrobe, .fastMode);

  // Clock, 100 ns period
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic summarize;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait for a channel 1 load
  task automatic waitStr;
    int i;
    for (i = 0; i < 300 && convStrobe[0] !== 1'b1; i++) @(posedge clk_sys);
    if (i == 300) begin
      n_fail++;
      summarize;
    end
    @(posedge clk_sys);
  endtask

  // Set value, skip one load, note the next expected code
  task automatic conv(input logic [15:0] v, input logic [15:0] e);
    ctrl_model_i.io(4'h1, v);
    waitStr;
    expQ.push_back(e);
    waitStr;
  endtask

  task automatic setup(input logic [15:0] rng, pol, tim, lo, hi);
    ctrl_model_i.cfg(6'h00, 16'h0001);
    ctrl_model_i.cfg(6'h01, rng);
    ctrl_model_i.cfg(6'h02, pol);
    ctrl_model_i.cfg(6'h12, tim);
    ctrl_model_i.cfg(6'h13, lo);
    ctrl_model_i.cfg(6'h14, hi);
    ctrl_model_i.restart;
    ctrl_model_i.io(4'h0, 16'h0001);
  endtask

  // Linear map onto 4000 counts, half away from zero
  function automatic logic [15:0] scl(input int v, lo, hi);
    int n;
    n = (v - lo) * 4000 / (hi - lo) * 2;
    n = (v - lo) * 8000 / (hi - lo);
    return 16'((n >= 0) ? (n + 1) / 2 : -((1 - n) / 2));
  endfunction

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // Compares each loaded channel 1 code with the oldest note
  always @(posedge clk_sys) begin
    if (convStrobe[0] === 1'b1 && expQ.size() > 0) begin
      chk(dacCode[15:0], expQ.pop_front());
    end
  end

  initial begin
    rst = 1'b1;
    ioRdAddr = 4'h9;
    flt = '0;
    seed = 32'h5BC1603C;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk(dacCode[15:0], 16'h0000);
    ctrl_model_i.cfg(6'h3F, 16'hFFFF);
    setup(16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h2710);
    conv(16'h0000, 16'h0000);
    conv(16'h2710, 16'h0FA0);
    conv(16'hFE0C, 16'hFF38);
    conv(16'h2904, 16'h1068);
    for (k = 0; k < 4; k++) begin
      seed = xs(seed);
      conv(16'(seed % 10001), scl(int'(seed % 10001), 0, 10000));
    end
    $display("scaling test done");
    setup(16'h0001, 16'h0000, 16'h0000, 16'h2710, 16'h0000);
    conv(16'h0000, 16'h0FA0);
    conv(16'h2904, 16'hFF38);
    conv(16'h09C5, 16'h0BB8);
    ctrl_model_i.cfg(6'h16, 16'h7D01);
    setup(16'h0001, 16'h0000, 16'h0000, 16'h0005, 16'h0005);
    conv(16'h04D2, 16'h04D2);
    chk(ioRdData & 16'h0301, 16'h0300);
    ctrl_model_i.cfg(6'h16, 16'h0000);
    ctrl_model_i.cfg(6'h23, 16'h0001);
    setup(16'h0002, 16'h0000, 16'h0100, 16'h0000, 16'h2710);
    conv(16'h0BB8, 16'h0BB8);
    chk({14'h0, fastMode, dacCurrent[0]}, 16'h0003);
    chk({12'h0, dacRange}, 16'h0002);
    $display("limit test done");
    for (r = 0; r < 2; r++) begin
      for (p = 0; p < 3; p++) begin
        setup(16'(1 - r), 16'hA500 | 16'(p), 16'h0000, 16'h0000, 16'h0000);
        conv(16'h07D0, 16'h07D0);
        ctrl_model_i.io(4'h0, 16'h0000);
        repeat (4) @(posedge clk_sys);
        chk(dacCode[15:0], polTab[r * 3 + p]);
      end
    end
    $display("stop policy test done");
    ctrl_model_i.io(4'h0, 16'h0001);
    ctrl_model_i.io(4'h1, 16'h1388);
    repeat (45) @(posedge clk_sys);
    chk(dacCode[15:0], 16'h0898);
    chk(ioRdData & 16'h0301, 16'h0001);
    conv(16'h0064, 16'h0064);
    chk(ioRdData & 16'h0301, 16'h0000);
    // Read back the exchange words
    ioRdAddr <= 4'h1;
    repeat (2) @(posedge clk_sys);
    chk(ioRdData, 16'h0064);
    ioRdAddr <= 4'h0;
    repeat (2) @(posedge clk_sys);
    chk(ioRdData, 16'h0001);
    ioRdAddr <= 4'h9;
    $display("setting error test done");
    ctrl_model_i.io(4'h0, 16'h0003);
    repeat (4) @(posedge clk_sys);
    chk({14'h0, convActive}, 16'h0001);
    chk(dacCode[31:16], 16'h0000);
    for (k = 0; k < 7; k++) begin
      flt <= (k == 6) ? 11'h280 : 11'h001 << k;
      repeat (8) @(posedge clk_sys);
      chk({15'h0, convActive[0]}, 16'h0000);
      flt <= '0;
      repeat (4) @(posedge clk_sys);
      ctrl_model_i.io(4'h0, 16'h0001);
      repeat (4) @(posedge clk_sys);
      chk({15'h0, convActive[0]}, 16'h0001);
    end
    $display("stop cause test done");
    // Reset in mid-run clears enables and selection
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk({14'h0, convActive}, 16'h0000);
    chk(dacCode[15:0], 16'h0000);
    $display("reset test done");
    summarize;
  end
endmodule
`default_nettype wire
